// ---- erd_pkg.sv ----
// constants, state encoding and state record for the receive slave dma block
package erd_pkg;

   // register offsets, 16-bit registers on a plain port
   localparam logic [9:0] OFF_CHAN = 10'h024;
   localparam logic [9:0] OFF_SOF = 10'h026;
   localparam logic [9:0] OFF_FCNT = 10'h028;
   localparam logic [9:0] OFF_BCNT = 10'h02a;
   localparam logic [9:0] OFF_RECEIVE_CONFIG_REG = 10'h102;
   localparam logic [9:0] OFF_BUFFER_CONFIG_REG = 10'h10a;
   localparam logic [9:0] OFF_BUS_CONTROL_REG = 10'h116;
   localparam logic [9:0] OFF_RXEVT = 10'h124;
   localparam logic [9:0] OFF_BUFEVT = 10'h12c;
   localparam logic [9:0] OFF_MISS = 10'h130;

   // field positions
   localparam int RECEIVE_CONFIG_REG_STREAM = 7;
   localparam int RECEIVE_CONFIG_REG_EXCL = 9;
   localparam int RECEIVE_CONFIG_REG_AUTO = 10;
   localparam int BUFFER_CONFIG_REG_IRQ = 7;
   localparam int BUFEVT_PEND = 7;
   localparam int BUS_CONTROL_REG_RST = 6;
   localparam int BUS_CONTROL_REG_DUTY = 11;
   localparam int BUS_CONTROL_REG_RING = 13;

   // ring sizes and masks
   localparam logic [15:0] RING_MASK_SMALL = 16'h3fff;
   localparam logic [15:0] RING_MASK_LARGE = 16'hffff;
   localparam logic [16:0] RING_SIZE_SMALL = 17'h0_4000;
   localparam logic [16:0] RING_SIZE_LARGE = 17'h1_0000;

   localparam int FCNT_W = 12;
   localparam logic [1:0] CHAN_MAX = 2'h2;
   localparam logic [16:0] HDR_BYTES = 17'h0_0004;

   // request duty timing
   localparam int CLK_HZ = 20000000;
   localparam int REQ_HIGH_US = 28000;
   localparam int REQ_LOW_US = 1300;
   localparam int REQ_HIGH_CYC = REQ_HIGH_US * (CLK_HZ / 1000000);
   localparam int REQ_LOW_CYC = REQ_LOW_US * (CLK_HZ / 1000000);
   localparam int DUTY_W = 20;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_STAT,
      ST_LEN,
      ST_DATA,
      ST_DONE
   } erd_state_t;

   typedef struct packed {
      erd_state_t state;
      logic excl;
      logic auto_sw;
      logic stream;
      logic irq_en;
      logic ring_large;
      logic duty_lim;
      logic [1:0] chan;
      logic chan_cap;
      logic [15:0] sof;
      logic [FCNT_W-1:0] fcnt;
      logic [15:0] bcnt;
      logic pend;
      logic [15:0] miss;
      logic [15:0] wr_off;
      logic [15:0] frm_start;
      logic [15:0] pend_base;
      logic [15:0] commit_base;
      logic committed;
      logic newer;
      logic [15:0] stat;
      logic [15:0] len;
      logic [15:0] words;
      logic [10:0] ram_addr;
      logic [2:0] req;
      logic [DUTY_W-1:0] duty_cnt;
      logic duty_low;
      logic [15:0] data;
      logic oe;
      logic [15:0] rdata;
      logic release_p;
      logic irq_p;
   } erd_state_rec_t;

endpackage

// ---- erd_rx_dma.sv ----
// receive slave dma engine: on-chip frames to a host ring over dma pins
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps

// Overview of operation
// RL1: exclusive receive-dma bit sends every received frame through slave dma.
// RL2: exclusive bit wins over auto-switch enable; all frames then use dma.
// RL3: each frame lands with status and length words in host ring.
// RL4: channel register holds 0, 1 or 2, picking request/acknowledge pair.
// RL5: start-of-frame register gives ring offset of latest transferred frame.
// RL6: frame count, low 12 bits, counts frames since last read.
// RL7: byte count gives bytes moved since last read.
// RL8: ring-size bit picks 16 or 64 Kbyte ring; only offsets use it. The code also sizes the free-space check by it.
// RL9: request rises only once a whole accepted frame sits on chip.
// RL10: host dma controller grants by pulling acknowledge low.
// RL11: status word first, then length word, then frame data.
// RL12: duty limit clear keeps request high through the whole frame.
// RL13: duty limit set: request about 28 ms high, 1.3 ms low, repeating.
// RL14: frame end updates counters, sets pending flag, frees on-chip space.
// RL15: interrupt enable set raises interrupt at each frame completion.
// RL16: missed-frame counter counts lost frames in every mode.
// RL17: in dma mode the receive event word reads zero.
// RL18: ring space commits after full transfer and a frame count read.
// RL19: later frames never overwrite committed ring space.
// RL20: reread, implied skip or ring reset command releases the commitment.
// RL21: 16-bit words, each frame starts on a 32-bit boundary.
// RL22: pending flag follows nonzero frame count; event reads leave it.
// RL23: only received frames travel over this dma path.
// RL24: write offset wraps to zero at the selected ring size.
module erd_rx_dma #(
   parameter int REQ_HIGH_CYCLES = erd_pkg::REQ_HIGH_CYC,
   parameter int REQ_LOW_CYCLES = erd_pkg::REQ_LOW_CYC
) (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic [9:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [15:0] reg_rdata_o,
   input wire logic [1:0] chan_strap_i,
   input wire logic frame_ready_i,
   input wire logic [15:0] frame_status_i,
   input wire logic [15:0] frame_len_i,
   input wire logic [15:0] ram_data_i,
   input wire logic auto_switch_req_i,
   input wire logic stream_end_i,
   input wire logic frame_missed_i,
   input wire logic [15:0] rx_event_i,
   input wire logic [2:0] dma_ack_n_i,
   output logic [2:0] dma_req_o,
   output logic [15:0] dma_data_o,
   output logic dma_data_oe_o,
   output logic [15:0] host_off_o,
   output logic [10:0] ram_addr_o,
   output logic frame_release_o,
   output logic dma_mode_o,
   output logic dma_irq_o
);

   erd_pkg::erd_state_rec_t r_r;
   erd_pkg::erd_state_rec_t r_nxt;
   logic [2:0] take_vec;
   logic take;
   logic dma_mode;
   logic [15:0] ring_mask;
   logic [16:0] ring_size;
   logic [16:0] need;
   logic [16:0] used;
   logic active;

   localparam logic [erd_pkg::DUTY_W-1:0] HIGH_LAST =
      erd_pkg::DUTY_W'(REQ_HIGH_CYCLES - 1);
   localparam logic [erd_pkg::DUTY_W-1:0] LOW_LAST =
      erd_pkg::DUTY_W'(REQ_LOW_CYCLES - 1);

   // a word moves when a raised request meets a low acknowledge
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_chan
         assign take_vec[gi] = r_r.req[gi] & ~dma_ack_n_i[gi]; // [RL10]
      end
   endgenerate
   assign take = |take_vec;

   assign dma_mode = r_r.excl | (r_r.auto_sw & auto_switch_req_i); // [RL1] [RL2]
   assign ring_mask = r_r.ring_large ? erd_pkg::RING_MASK_LARGE
                                     : erd_pkg::RING_MASK_SMALL; // [RL8]
   assign ring_size = r_r.ring_large ? erd_pkg::RING_SIZE_LARGE
                                     : erd_pkg::RING_SIZE_SMALL;
   // header plus frame rounded up to a double word
   assign need = erd_pkg::HDR_BYTES +
      (({1'b0, frame_len_i} + 17'h0_0003) & 17'h1_fffc); // [RL21]
   assign used = {1'b0, (r_r.wr_off - r_r.commit_base) & ring_mask};

   always_comb
   begin
      r_nxt = r_r;
      r_nxt.rdata = 16'h0000;
      r_nxt.release_p = 1'b0;
      r_nxt.irq_p = 1'b0;

      // channel is strapped once after reset release; 3 is out of range
      if (!r_r.chan_cap)
      begin
         r_nxt.chan_cap = 1'b1;
         r_nxt.chan = (chan_strap_i > erd_pkg::CHAN_MAX) ? erd_pkg::CHAN_MAX
                                                        : chan_strap_i; // [RL4]
      end

      // register writes
      if (reg_wr_i)
      begin
         unique case (reg_addr_i)
            erd_pkg::OFF_RECEIVE_CONFIG_REG:
            begin
               r_nxt.stream = reg_wdata_i[erd_pkg::RECEIVE_CONFIG_REG_STREAM];
               r_nxt.excl = reg_wdata_i[erd_pkg::RECEIVE_CONFIG_REG_EXCL];
               r_nxt.auto_sw = reg_wdata_i[erd_pkg::RECEIVE_CONFIG_REG_AUTO];
            end
            erd_pkg::OFF_BUFFER_CONFIG_REG:
               r_nxt.irq_en = reg_wdata_i[erd_pkg::BUFFER_CONFIG_REG_IRQ];
            erd_pkg::OFF_BUS_CONTROL_REG:
            begin
               r_nxt.duty_lim = reg_wdata_i[erd_pkg::BUS_CONTROL_REG_DUTY];
               r_nxt.ring_large = reg_wdata_i[erd_pkg::BUS_CONTROL_REG_RING];
               // ring reset: drop a frame in flight unless its status, length or last data word moves or the frame completes in the same cycle; a dropped frame stays on chip
               if (reg_wdata_i[erd_pkg::BUS_CONTROL_REG_RST])
               begin
                  r_nxt.committed = 1'b0; // [RL20]
                  r_nxt.newer = 1'b0;
                  r_nxt.wr_off = 16'h0000;
                  r_nxt.pend_base = 16'h0000;
                  r_nxt.commit_base = 16'h0000;
                  r_nxt.fcnt = '0;
                  r_nxt.bcnt = 16'h0000;
                  r_nxt.state = erd_pkg::ST_IDLE;
               end
            end
            default:
               r_nxt.rdata = 16'h0000;
         endcase
      end

      // register reads; read side effects come before hardware sets
      if (reg_rd_i)
      begin
         unique case (reg_addr_i)
            erd_pkg::OFF_CHAN:
               r_nxt.rdata = {14'h0000, r_r.chan};
            erd_pkg::OFF_SOF:
               r_nxt.rdata = r_r.sof; // [RL5]
            erd_pkg::OFF_FCNT:
            begin
               r_nxt.rdata = {4'h0, r_r.fcnt}; // [RL6]
               r_nxt.fcnt = '0;
               if (r_r.committed)
                  r_nxt.committed = 1'b0; // [RL20]
               else if (r_r.fcnt != '0)
               begin
                  r_nxt.committed = 1'b1; // [RL18]
                  r_nxt.commit_base = r_r.pend_base;
               end
               r_nxt.pend_base = r_r.wr_off;
               r_nxt.newer = 1'b0;
            end
            erd_pkg::OFF_BCNT:
            begin
               r_nxt.rdata = r_r.bcnt; // [RL7]
               r_nxt.bcnt = 16'h0000;
            end
            erd_pkg::OFF_RECEIVE_CONFIG_REG:
               r_nxt.rdata = {5'h00, r_r.auto_sw, r_r.excl, 1'b0,
                              r_r.stream, 7'h00};
            erd_pkg::OFF_BUFFER_CONFIG_REG:
               r_nxt.rdata = {8'h00, r_r.irq_en, 7'h00};
            erd_pkg::OFF_BUS_CONTROL_REG:
               r_nxt.rdata = {2'h0, r_r.ring_large, 1'b0, r_r.duty_lim,
                              11'h000};
            erd_pkg::OFF_RXEVT:
               r_nxt.rdata = dma_mode ? 16'h0000 : rx_event_i; // [RL17]
            erd_pkg::OFF_BUFEVT:
            begin
               // reading leaves the flag alone
               r_nxt.rdata = {8'h00, r_r.pend, 7'h00}; // [RL22]
               if (r_r.pend && r_r.newer && r_r.committed)
                  r_nxt.committed = 1'b0; // [RL20]
            end
            erd_pkg::OFF_MISS:
            begin
               r_nxt.rdata = r_r.miss;
               r_nxt.miss = 16'h0000;
            end
            default:
               r_nxt.rdata = 16'h0000;
         endcase
      end

      if (frame_missed_i)
         r_nxt.miss = r_nxt.miss + 16'h0001; // [RL16]

      // transfer sequencing; only receive frames ever enter here
      unique case (r_r.state)
         erd_pkg::ST_IDLE:
         begin
            // wait until the whole frame fits outside committed space
            if (dma_mode && frame_ready_i && r_nxt.state == erd_pkg::ST_IDLE
                && ((!r_r.committed && need <= ring_size)
                    || (r_r.committed && need <= ring_size - used)))
            begin // [RL9] [RL19] [RL23]
               r_nxt.state = erd_pkg::ST_STAT;
               r_nxt.stat = frame_status_i;
               r_nxt.len = frame_len_i;
               r_nxt.words = (frame_len_i >> 1) + {15'h0000, frame_len_i[0]};
               r_nxt.frm_start = r_r.wr_off;
               r_nxt.ram_addr = 11'h000;
            end
         end
         erd_pkg::ST_STAT:
            if (take)
            begin
               r_nxt.state = erd_pkg::ST_LEN; // [RL11]
               r_nxt.wr_off = (r_r.wr_off + 16'h0002) & ring_mask;
            end
         erd_pkg::ST_LEN:
            if (take)
            begin
               r_nxt.state = (r_r.words == 16'h0000) ? erd_pkg::ST_DONE
                                                     : erd_pkg::ST_DATA;
               r_nxt.wr_off = (r_r.wr_off + 16'h0002) & ring_mask;
            end
         erd_pkg::ST_DATA:
            if (take)
            begin
               r_nxt.words = r_r.words - 16'h0001;
               r_nxt.ram_addr = r_r.ram_addr + 11'h001;
               r_nxt.wr_off = (r_r.wr_off + 16'h0002) & ring_mask; // [RL24]
               if (r_r.words == 16'h0001)
                  r_nxt.state = erd_pkg::ST_DONE;
            end
         erd_pkg::ST_DONE:
         begin
            // next frame starts on a double word, wrapping inside the ring
            r_nxt.wr_off = (r_r.wr_off + 16'h0003) & 16'hfffc & ring_mask;
            r_nxt.sof = r_r.frm_start; // [RL14] [RL21] [RL24]
            r_nxt.fcnt = r_nxt.fcnt + 12'h001;
            r_nxt.bcnt = r_nxt.bcnt + 16'h0004 + r_r.len + {15'h0000, r_r.len[0]};
            r_nxt.newer = 1'b1;
            r_nxt.release_p = 1'b1;
            r_nxt.irq_p = r_r.irq_en; // [RL15]
            r_nxt.state = erd_pkg::ST_IDLE;
         end
         default:
            r_nxt.state = erd_pkg::ST_IDLE;
      endcase

      // pending flag: count going nonzero, or stream end in stream mode
      if (r_nxt.fcnt == '0)
         r_nxt.pend = 1'b0; // [RL22]
      else if (r_r.stream ? stream_end_i : (r_r.fcnt == '0))
         r_nxt.pend = 1'b1; // [RL14]

      active = (r_nxt.state == erd_pkg::ST_STAT)
            || (r_nxt.state == erd_pkg::ST_LEN)
            || (r_nxt.state == erd_pkg::ST_DATA);

      // duty limit: the counter only runs while a frame is in flight
      if (active && r_r.duty_lim)
      begin // [RL13]
         r_nxt.duty_cnt = r_r.duty_cnt + 1'b1;
         if (!r_r.duty_low && r_r.duty_cnt >= HIGH_LAST)
         begin
            r_nxt.duty_low = 1'b1;
            r_nxt.duty_cnt = '0;
         end
         else if (r_r.duty_low && r_r.duty_cnt >= LOW_LAST)
         begin
            r_nxt.duty_low = 1'b0;
            r_nxt.duty_cnt = '0;
         end
      end
      else
      begin // [RL12]
         r_nxt.duty_cnt = '0;
         r_nxt.duty_low = 1'b0;
      end

      r_nxt.req = (active && !r_nxt.duty_low) ? (3'b001 << r_nxt.chan)
                                              : 3'b000; // [RL4] [RL9]
      r_nxt.oe = active;

      // word presented for the next acknowledge
      unique case (r_nxt.state)
         erd_pkg::ST_STAT:
            r_nxt.data = r_nxt.stat; // [RL3] [RL11]
         erd_pkg::ST_LEN:
            r_nxt.data = r_nxt.len; // [RL3] [RL11]
         erd_pkg::ST_DATA:
            r_nxt.data = ram_data_i;
         default:
            r_nxt.data = 16'h0000;
      endcase
   end

   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
         r_r <= '0;
      else
         r_r <= r_nxt;
   end

   assign reg_rdata_o = r_r.rdata;
   assign dma_req_o = r_r.req;
   assign dma_data_o = r_r.data;
   assign dma_data_oe_o = r_r.oe;
   assign host_off_o = r_r.wr_off;
   assign ram_addr_o = r_r.ram_addr;
   assign frame_release_o = r_r.release_p;
   assign dma_mode_o = dma_mode;
   assign dma_irq_o = r_r.irq_p;

endmodule

// ---- erd_rx_dma_properties.sv ----
// concurrent checks on the ports of the receive slave dma block
`timescale 1ns/1ps
module erd_rx_dma_properties (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic [9:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [15:0] reg_rdata_o,
   input wire logic frame_ready_i,
   input wire logic [15:0] frame_status_i,
   input wire logic [2:0] dma_req_o,
   input wire logic [15:0] dma_data_o,
   input wire logic dma_data_oe_o,
   input wire logic [15:0] host_off_o,
   input wire logic frame_release_o,
   input wire logic dma_mode_o,
   input wire logic dma_irq_o
);
   // shadow of the bus control bits the checks depend on
   logic duty_r;
   logic ring_r;
   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
      begin
         duty_r <= 1'b0;
         ring_r <= 1'b0;
      end
      else if (reg_wr_i && reg_addr_i == erd_pkg::OFF_BUS_CONTROL_REG)
      begin
         duty_r <= reg_wdata_i[erd_pkg::BUS_CONTROL_REG_DUTY];
         ring_r <= reg_wdata_i[erd_pkg::BUS_CONTROL_REG_RING];
      end
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   AST_REQ_ONE_PAIR: assert property ($onehot0(dma_req_o))
      else $error("more than one request line high");
   AST_REQ_AFTER_FRAME: assert property (
      $rose(|dma_req_o) |-> $past(frame_ready_i))
      else $error("request without a waiting frame");
   AST_RXEVT_ZERO: assert property (
      reg_rd_i && reg_addr_i == erd_pkg::OFF_RXEVT && dma_mode_o
      |=> reg_rdata_o == 16'h0000) else $error("event word not zero");
   AST_FCNT_TOP: assert property (
      reg_rd_i && reg_addr_i == erd_pkg::OFF_FCNT
      |=> reg_rdata_o[15:12] == 4'h0) else $error("count top bits set");
   AST_IRQ_AT_END: assert property (dma_irq_o |-> frame_release_o)
      else $error("interrupt outside frame completion");
   AST_RELEASE_ONCE: assert property (
      frame_release_o |=> !frame_release_o)
      else $error("release longer than one cycle");
   AST_REQ_WHOLE: assert property (
      $fell(|dma_req_o) && !duty_r |=> frame_release_o)
      else $error("request dropped before frame end");
   AST_REQ_PAUSE: assert property (
      $fell(|dma_req_o) && duty_r |-> (dma_req_o == 3'h0) [*4])
      else $error("request pause too short");
   AST_START_ALIGN: assert property (
      $rose(dma_data_oe_o) |-> host_off_o[1:0] == 2'h0)
      else $error("frame start not aligned");
   AST_STATUS_FIRST: assert property (
      $rose(dma_data_oe_o) |-> dma_data_o == frame_status_i)
      else $error("first word not the status");
   AST_RING_SMALL: assert property (
      dma_data_oe_o && !ring_r |-> host_off_o[15:14] == 2'h0)
      else $error("offset outside small ring");
endmodule

// ---- erd_host_dma.sv ----
// host dma controller model: one acknowledge pulse per word
`timescale 1ns/1ps
module erd_host_dma (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic [2:0] req_i,
   input wire logic [1:0] ch_i,
   input wire logic slow_i,
   output logic [2:0] ack_n_o
);
   logic [1:0] gap_r;
   // ack idles high; slow mode stretches the gap between grants
   always @(posedge mclk_i)
   begin
      if (!nrst_i || ack_n_o != 3'h7)
      begin
         ack_n_o <= 3'h7;
         gap_r <= slow_i ? 2'h3 : 2'h0;
      end
      else if (gap_r != 2'h0)
         gap_r <= gap_r - 2'h1;
      else if (req_i[ch_i])
         ack_n_o[ch_i] <= 1'b0;
   end
endmodule

// ---- erd_rx_dma_bench.sv ----
// self-checking bench for the receive slave dma block
`timescale 1ns/1ps
module erd_rx_dma_bench;
   logic mclk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [9:0] reg_addr_i = 10'h000;
   logic [15:0] reg_wdata_i = 16'h0000;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic frame_ready_i = 1'b0;
   logic [15:0] frame_status_i = 16'h0000;
   logic [15:0] frame_len_i = 16'h0000;
   logic auto_switch_req_i = 1'b0;
   logic frame_missed_i = 1'b0;
   logic [15:0] rx_event_i = 16'h0000;
   logic slow = 1'b0;
   logic rd_q = 1'b0;
   logic [15:0] lfsr = 16'h936a;
   logic [15:0] reg_rdata_o, dma_data_o, host_off_o, ram_data_i;
   logic [2:0] dma_ack_n_i, dma_req_o;
   logic [10:0] ram_addr_o;
   logic dma_data_oe_o, frame_release_o, dma_mode_o, dma_irq_o;
   logic [15:0] mem [0:31];
   logic [15:0] rq [$];
   logic [15:0] dq [$];
   int err_total = 0;
   int n_compared = 0;
   int k;
   assign ram_data_i = mem[ram_addr_o[4:0]];
   always #25 mclk_i = ~mclk_i;
   erd_rx_dma #(.REQ_HIGH_CYCLES(20), .REQ_LOW_CYCLES(5)) dut_u (
      .mclk_i(mclk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .chan_strap_i(2'h3),
      .frame_ready_i(frame_ready_i), .frame_status_i(frame_status_i),
      .frame_len_i(frame_len_i), .ram_data_i(ram_data_i),
      .auto_switch_req_i(auto_switch_req_i), .stream_end_i(1'b0),
      .frame_missed_i(frame_missed_i), .rx_event_i(rx_event_i),
      .dma_ack_n_i(dma_ack_n_i), .dma_req_o(dma_req_o),
      .dma_data_o(dma_data_o), .dma_data_oe_o(dma_data_oe_o),
      .host_off_o(host_off_o), .ram_addr_o(ram_addr_o),
      .frame_release_o(frame_release_o), .dma_mode_o(dma_mode_o),
      .dma_irq_o(dma_irq_o));
   erd_host_dma host_u (.mclk_i(mclk_i), .nrst_i(nrst_i), .req_i(dma_req_o),
      .ch_i(2'h2), .slow_i(slow), .ack_n_o(dma_ack_n_i));
   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge mclk_i)
   begin
      rd_q <= reg_rd_i;
      if (rd_q)
         check("reg_rdata_o", reg_rdata_o, rq.pop_front());
      if (dma_req_o[2] && !dma_ack_n_i[2])
         check("dma_data_o", dma_data_o, dq.pop_front());
   end
   task wr(input logic [9:0] a, input logic [15:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
      @(posedge mclk_i);
   endtask
   task rd(input logic [9:0] a, input logic [15:0] e);
      rq.push_back(e);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
      @(posedge mclk_i);
   endtask
   // frame_ready_i drops in the completion cycle so no second start
   task frame(input logic [15:0] len, input logic irq);
      int i;
      for (i = 0; i < 32; i++)
      begin
         lfsr = lfsr_next(lfsr);
         mem[i] = lfsr;
      end
      frame_status_i <= lfsr ^ 16'h5a5a;
      frame_len_i <= len;
      frame_ready_i <= 1'b1;
      dq.push_back(lfsr ^ 16'h5a5a);
      dq.push_back(len);
      for (i = 0; i < len / 2; i++)
         dq.push_back(mem[i]);
      i = 0;
      while ((dq.size() != 0 || dma_req_o != 3'h0) && i < 3000)
      begin
         @(posedge mclk_i);
         i++;
      end
      frame_ready_i <= 1'b0;
      while (frame_release_o !== 1'b1 && i < 3000)
      begin
         @(posedge mclk_i);
         i++;
      end
      check("dma_irq_o", {15'h0, dma_irq_o}, {15'h0, irq});
      @(posedge mclk_i);
   endtask
   initial
   begin
      repeat (20000) @(posedge mclk_i);
      err_total++;
      report_and_stop();
   end
   initial
   begin
      repeat (8) @(posedge mclk_i);
      nrst_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      rd(erd_pkg::OFF_CHAN, 16'h0002);
      rd(10'h3fe, 16'h0000);
      for (k = 0; k < 4; k++)
      begin
         auto_switch_req_i <= k[0];
         wr(erd_pkg::OFF_RECEIVE_CONFIG_REG, k[1] ? 16'h0600 : 16'h0400);
         check("dma_mode_o", {15'h0, dma_mode_o}, {15'h0, k[1] | k[0]});
      end
      rx_event_i <= 16'hffff;
      rd(erd_pkg::OFF_RXEVT, 16'h0000);
      wr(erd_pkg::OFF_BUFFER_CONFIG_REG, 16'h0080);
      frame(16'h0006, 1'b1);
      rd(erd_pkg::OFF_BUFEVT, 16'h0080);
      rd(erd_pkg::OFF_BUFEVT, 16'h0080);
      rd(erd_pkg::OFF_SOF, 16'h0000);
      rd(erd_pkg::OFF_BCNT, 16'h000a);
      rd(erd_pkg::OFF_FCNT, 16'h0001);
      rd(erd_pkg::OFF_FCNT, 16'h0000);
      rd(erd_pkg::OFF_BUFEVT, 16'h0000);
      repeat (2)
      begin
         frame_missed_i <= 1'b1;
         @(posedge mclk_i);
         frame_missed_i <= 1'b0;
         @(posedge mclk_i);
      end
      rd(erd_pkg::OFF_MISS, 16'h0002);
      rd(erd_pkg::OFF_MISS, 16'h0000);
      wr(erd_pkg::OFF_BUFFER_CONFIG_REG, 16'h0000);
      wr(erd_pkg::OFF_BUS_CONTROL_REG, 16'h0800);
      slow <= 1'b1;
      frame(16'h0028, 1'b0);
      rd(erd_pkg::OFF_SOF, 16'h000c);
      rd(erd_pkg::OFF_BCNT, 16'h002c);
      wr(erd_pkg::OFF_BUS_CONTROL_REG, 16'h0040);
      rd(erd_pkg::OFF_FCNT, 16'h0000);
      rd(erd_pkg::OFF_BCNT, 16'h0000);
      report_and_stop();
   end
endmodule
bind erd_rx_dma erd_rx_dma_properties chk_u (.mclk_i(mclk_i),
   .nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .frame_ready_i(frame_ready_i), .frame_status_i(frame_status_i),
   .dma_req_o(dma_req_o), .dma_data_o(dma_data_o),
   .dma_data_oe_o(dma_data_oe_o), .host_off_o(host_off_o),
   .frame_release_o(frame_release_o), .dma_mode_o(dma_mode_o),
   .dma_irq_o(dma_irq_o));
